// ===== hdl/pmt_pkg.sv
/*
  Shared constants and carriers of the period match timer: register
  indices, field positions, reset values and scaler limits.
  Assumes a 32-bit Avalon-MM slave with byte addresses, word per register.
*/
package pmt_pkg;

  // ****************************************************************
  // bus layout
  // ****************************************************************
  localparam int          ADDR_W      = 10;
  localparam int          DATA_W      = 32;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_FLAGS   = 8'h0C;
  localparam logic [7:0]  IDX_CNT     = 8'h11;
  localparam logic [7:0]  IDX_CTL     = 8'h12;
  localparam logic [7:0]  IDX_EN      = 8'h8C;
  localparam logic [7:0]  IDX_PER     = 8'h92;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          FLAG_BIT    = 1;
  localparam int          CTL_PRE_LSB = 0;
  localparam int          CTL_RUN_BIT = 2;
  localparam int          CTL_POST_LSB = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  PER_RST     = 8'hFF;
  localparam logic [7:0]  CNT_RST     = 8'h00;
  localparam logic [6:0]  CTL_RST     = 7'h00;
  localparam logic [3:0]  SCALE_RST   = 4'h0;

  // ****************************************************************
  // prescaler terminal counts
  // ****************************************************************
  localparam logic [3:0]  PRE_LIM_DIV1  = 4'h0;
  localparam logic [3:0]  PRE_LIM_DIV4  = 4'h3;
  localparam logic [3:0]  PRE_LIM_DIV16 = 4'hF;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0] postscale;
    logic       run;
    logic [1:0] prescale;
  } pmt_ctl_s;

  typedef struct packed {
    logic [7:0] count;
    logic       match;
  } pmt_tbase_s;

endpackage

// ===== hdl/pmt_prescaler.sv
/*
  Input prescaler: divides the instruction clock by 1, 4 or 16.
  Assumes clear and run come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_prescaler
  import pmt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // result
  output logic            tick,
  output logic [3:0]      count
);

  logic [3:0] limit;

  always_comb begin
    unique case (sel)
      2'b00:   limit = PRE_LIM_DIV1;
      2'b01:   limit = PRE_LIM_DIV4;
      default: limit = PRE_LIM_DIV16;
    endcase
  end

  assign tick = run && (count == limit);

  // counting halts with run low, so the divider stays where it is
  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      count <= SCALE_RST;
    end else if (tick) begin
      count <= SCALE_RST;
    end else if (run) begin
      count <= count + 4'h1;
    end
  end

endmodule // pmt_prescaler
`default_nettype wire

// ===== hdl/pmt_postscaler.sv
/*
  Match postscaler: one pulse every sel+1 matches.
  Assumes match is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_postscaler
  import pmt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic       match,
  input  wire logic [3:0] sel,
  // result
  output logic            pulse,
  output logic [3:0]      count
);

  // clear beats a coincident match, the write restarts the ratio
  assign pulse = match && !clear && (count == sel);

  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      count <= SCALE_RST;
    end else if (pulse) begin
      count <= SCALE_RST;
    end else if (match) begin
      count <= count + 4'h1;
    end
  end

endmodule // pmt_postscaler
`default_nettype wire

// ===== hdl/pmt_timer.sv
/*
  Period match timer, top level: Avalon-MM register slave, 8-bit counter
  with period compare, prescaler and postscaler, match flag and interrupt.
  Assumes a single clk_sys domain and a master that holds its request
  until it sees waitrequest low.
*/
// The Avalon-MM slave port is this design's own decision.
// Notes on behaviour
// - counter rises from zero to period, then returns to zero next increment
// - period register is read/write and resets to all ones
// - counter register is read/write and cleared by every reset
// - prescaler divides by 1, 4 or 16 by a two-bit select
// - postscaler flags once every N+1 matches, N from 0 to 15
// - postscaled match sets flag bit 1, held until software clears it
// - writes to counter or control, and reset, clear both scaler counters
// - writing control never changes the counter value
// - run bit 2 enables counting; cleared, counting stops
// - control bits: postscale 6..3, run 2, prescale 1..0
// - unscaled match pulse goes to the serial port as a shift tick
// - counter value and match are offered to the PWM time base
`timescale 1ns/1ps
`default_nettype none
module pmt_timer
  import pmt_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // interrupt
  output logic                   irq,
  // neighbours
  output logic                   ssp_shift_tick,
  output var pmt_tbase_s         pwm_time_base
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic              waitrequest_q;
  logic [DATA_W-1:0] readdata_q;
  logic [DATA_W-1:0] readdata_d;
  pmt_ctl_s          ctl_q;
  logic [7:0]        per_q;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic              flag_q;
  logic              flag_d;
  logic              en_q;
  logic              irq_q;
  logic              match_q;
  logic              wr_ok;
  logic              wr_flags;
  logic              wr_ctl;
  logic              wr_en;
  logic              wr_cnt;
  logic              wr_per;
  logic              scaler_clr;
  logic              pre_tick;
  logic [3:0]        pre_cnt;
  logic              cnt_match;
  logic              post_pulse;
  logic [3:0]        post_cnt;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        idx);
    reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // a request is taken at the edge where waitrequest is seen low
  assign wr_ok    = avs_write && !waitrequest_q && avs_byteenable[0];
  assign wr_flags = wr_ok && reg_hit(avs_address, IDX_FLAGS);
  assign wr_ctl   = wr_ok && reg_hit(avs_address, IDX_CTL);
  assign wr_en    = wr_ok && reg_hit(avs_address, IDX_EN);
  assign wr_cnt   = wr_ok && reg_hit(avs_address, IDX_CNT);
  assign wr_per   = wr_ok && reg_hit(avs_address, IDX_PER);

  // ****************************************************************
  // bus handshake
  // ****************************************************************
  // one wait cycle per access; readdata is captured as waitrequest drops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
    end else if (!waitrequest_q) begin
      waitrequest_q <= 1'b1;
    end else if (avs_read || avs_write) begin
      waitrequest_q <= 1'b0;
    end
  end

  always_comb begin
    readdata_d = '0;
    if (reg_hit(avs_address, IDX_FLAGS)) begin
      readdata_d[FLAG_BIT] = flag_q;
    end else if (reg_hit(avs_address, IDX_EN)) begin
      readdata_d[FLAG_BIT] = en_q;
    end else if (reg_hit(avs_address, IDX_CTL)) begin
      readdata_d[6:0] = ctl_q;
    end else if (reg_hit(avs_address, IDX_CNT)) begin
      readdata_d[7:0] = cnt_q;
    end else if (reg_hit(avs_address, IDX_PER)) begin
      readdata_d[7:0] = per_q;
    end
  end

  // unmapped addresses read as zero; writes to them are dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readdata_q <= '0;
    end else if (avs_read && waitrequest_q) begin
      readdata_q <= readdata_d;
    end
  end

  // ****************************************************************
  // control and period registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctl_q <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_q.postscale <= avs_writedata[CTL_POST_LSB +: 4];
      ctl_q.run       <= avs_writedata[CTL_RUN_BIT];
      ctl_q.prescale  <= avs_writedata[CTL_PRE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      per_q <= PER_RST;
    end else if (wr_per) begin
      per_q <= avs_writedata[7:0];
    end
  end

  // ****************************************************************
  // scalers
  // ****************************************************************
  assign scaler_clr = wr_cnt || wr_ctl;

  pmt_prescaler u_pre (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (scaler_clr),
    .run     (ctl_q.run),
    .sel     (ctl_q.prescale),
    .tick    (pre_tick),
    .count   (pre_cnt)
  );

  // a counter write overrides the increment of the same cycle
  assign cnt_match = pre_tick && !wr_cnt && (cnt_q == per_q);

  pmt_postscaler u_post (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (scaler_clr),
    .match   (cnt_match),
    .sel     (ctl_q.postscale),
    .pulse   (post_pulse),
    .count   (post_cnt)
  );

  // ****************************************************************
  // counter
  // ****************************************************************
  // control writes do not touch the count, only the scalers
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) begin
      cnt_d = avs_writedata[7:0];
    end else if (cnt_match) begin
      cnt_d = CNT_RST;
    end else if (pre_tick) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= cnt_match;
    end
  end

  // ****************************************************************
  // flag, enable and interrupt
  // ****************************************************************
  // a new event beats a clearing write in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (post_pulse) begin
      flag_d = 1'b1;
    end else if (wr_flags && avs_writedata[FLAG_BIT]) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (wr_en) begin
      en_q <= avs_writedata[FLAG_BIT];
    end
  end

  // built from flag_d so the request rises together with the flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_d && en_q;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata          = readdata_q;
  assign avs_waitrequest       = waitrequest_q;
  assign irq                   = irq_q;
  assign ssp_shift_tick        = match_q;
  assign pwm_time_base         = '{count: cnt_q, match: match_q};

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_div4_steady;
    (pre_tick && ctl_q.prescale == 2'b01 && !scaler_clr)
      ##1 (ctl_q.run && !scaler_clr) [*3];
  endsequence

  sequence s_wrap;
    pre_tick && !wr_cnt && cnt_q == per_q;
  endsequence

  chk_counter_wrap: assert property (
    s_wrap |=> cnt_q == 8'h00 && match_q)
    else $error("counter did not return to zero after period match");

  chk_counter_step: assert property (
    pre_tick && !wr_cnt && cnt_q != per_q |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not advance by one on a tick");

  chk_period_reset: assert property (
    $past(rst) |-> per_q == 8'hFF && cnt_q == 8'h00)
    else $error("period or counter wrong after reset");

  chk_count_write: assert property (
    wr_cnt |=> cnt_q == $past(avs_writedata[7:0]))
    else $error("counter write was not stored");

  chk_prescale_div4: assert property (
    s_div4_steady |=> pre_tick)
    else $error("divide-by-four prescaler tick spacing wrong");

  // a control write may legally switch to a faster ratio inside the gap
  chk_prescale_gap: assert property (
    pre_tick && ctl_q.prescale[1] && !scaler_clr |=> (!pre_tick || !ctl_q.prescale[1]) [*8])
    else $error("divide-by-sixteen prescaler ticked too early");

  chk_postscale_ratio: assert property (
    post_pulse |-> cnt_match && post_cnt == ctl_q.postscale)
    else $error("postscaler pulse at wrong match count");

  chk_flag_latch: assert property (
    post_pulse |=> flag_q ##1 (flag_q || $past(wr_flags)))
    else $error("match flag not latched");

  chk_flag_hold: assert property (
    flag_q && !wr_flags |=> flag_q)
    else $error("match flag dropped without a clear");

  chk_scalers_clear: assert property (
    scaler_clr |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scaler counters not cleared by write");

  chk_ctl_keeps_count: assert property (
    wr_ctl && !pre_tick |=> cnt_q == $past(cnt_q))
    else $error("control write disturbed the counter");

  chk_run_stop: assert property (
    !ctl_q.run && !wr_cnt |=> cnt_q == $past(cnt_q) && !match_q)
    else $error("counter moved while stopped");

  chk_irq_level: assert property (
    flag_q && en_q && !wr_flags |=> irq_q)
    else $error("interrupt not raised for enabled flag");

  chk_irq_quiet: assert property (
    !en_q |=> !irq_q)
    else $error("interrupt raised while disabled");

  chk_zero_period: assert property (
    per_q == 8'h00 && pre_tick && !wr_cnt |=> match_q && cnt_q == 8'h00)
    else $error("zero period did not match on every tick");

  chk_bus_answer: assert property (
    (avs_read || avs_write) && waitrequest_q |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one wait cycle");

  chk_wait_idle: assert property (
    !avs_read && !avs_write && waitrequest_q |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");

  chk_period_write: assert property (
    wr_per |=> per_q == $past(avs_writedata[7:0]))
    else $error("period write was not stored");

  chk_tbase_match: assert property (
    cnt_match |=> ssp_shift_tick && pwm_time_base.match && pwm_time_base.count == 8'h00)
    else $error("match outputs did not follow a period match");

endmodule // pmt_timer
`default_nettype wire

// ===== verification/period_match_timer8_test.sv
/*
  Self-checking bench of the period match timer: register access over
  Avalon-MM, scaler ratios, match outputs, flag and interrupt.
  Assumes pmt_timer and its package are compiled first; one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8_test
  import pmt_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic              clk_sys;
  logic              rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [3:0]        avs_byteenable;
  logic [DATA_W-1:0] avs_writedata;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  logic              ssp_shift_tick;
  pmt_tbase_s        pwm_time_base;
  logic [31:0]       exp_q[$];
  int                errors;
  int                n_tests;
  int                cyc;
  integer            seed;

  pmt_timer dut (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq),
    .ssp_shift_tick  (ssp_shift_tick),
    .pwm_time_base   (pwm_time_base)
  );

  always #10 clk_sys = ~clk_sys;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic end_of_test;
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be = 4'h1);
    @(posedge clk_sys);
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write      <= 1'b0;
  endtask

  // expected value is noted; the monitor compares at the accept edge
  task automatic bus_rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back({24'h00_0000, exp});
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_read    <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read    <= 1'b0;
  endtask

  // cycles from now until the next unscaled match pulse
  task automatic tick_gap(output int g);
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (ssp_shift_tick !== 1'b1 && g < 400);
  endtask

  // ****************************************************************
  // monitor and watchdog
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (rst === 1'b0) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
        if (exp_q.size() == 0)
          check(32'h0000_0001, 32'h0000_0000, "read without note");
        else
          check(avs_readdata, exp_q.pop_front(), "read data");
      end
      if (ssp_shift_tick === 1'b1)
        check({24'h00_0000, pwm_time_base.count}, 32'h0000_0000, "count at match");
      check({31'h0000_0000, pwm_time_base.match}, {31'h0000_0000, ssp_shift_tick},
            "time base match");
    end
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      end_of_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin : main
    logic [31:0] v;
    int          g;
    int          cnt;
    int          dv;
    logic [3:0]  n;
    clk_sys = 1'b0;
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = '0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    seed = 32'hd683_ca0c;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    bus_rd(IDX_PER, 8'hFF);
    bus_rd(IDX_CNT, 8'h00);
    bus_rd(IDX_CTL, 8'h00);
    bus_rd(IDX_FLAGS, 8'h00);
    bus_rd(IDX_EN, 8'h00);
    bus_wr(8'h55, 8'hA5);
    bus_rd(8'h55, 8'h00);
    v = $random(seed);
    bus_wr(IDX_PER, v[7:0]);
    bus_wr(IDX_PER, ~v[7:0], 4'h0);
    bus_rd(IDX_PER, v[7:0]);
    bus_wr(IDX_CNT, v[15:8]);
    bus_rd(IDX_CNT, v[15:8]);
    bus_wr(IDX_CTL, 8'hFB);
    bus_rd(IDX_CTL, 8'h7B);
    bus_wr(IDX_CTL, 8'h01);
    repeat (20) @(posedge clk_sys);
    bus_rd(IDX_CNT, v[15:8]);
    // ratio of each prescale code, at period zero and two
    for (int p = 0; p <= 2; p += 2) begin
      for (int s = 0; s < 4; s++) begin
        dv = (s == 0) ? 1 : (s == 1) ? 4 : 16;
        bus_wr(IDX_PER, p[7:0]);
        bus_wr(IDX_CNT, 8'h00);
        bus_wr(IDX_CTL, 8'h04 | s[7:0]);
        tick_gap(g);
        tick_gap(g);
        check(g, (p + 1) * dv, "match spacing");
      end
    end
    // scaler clear by writes: gap after a write must not depend on phase
    bus_wr(IDX_PER, 8'h00);
    bus_wr(IDX_CTL, 8'h06);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      repeat (1 + v[3:0]) @(posedge clk_sys);
      bus_wr(IDX_CNT, 8'h00);
      tick_gap(g);
      // sixteen clocks to the first tick, one more for the registered match
      check(g, 16 + 1, "gap after counter write");
    end
    // postscale ratios, sticky flag, interrupt masking
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      n = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : v[3:0];
      bus_wr(IDX_CTL, 8'h00);
      bus_wr(IDX_FLAGS, 8'h02);
      bus_rd(IDX_FLAGS, 8'h00);
      bus_wr(IDX_EN, 8'h02);
      bus_wr(IDX_CTL, {1'b0, n, 3'b100});
      cnt = 0;
      for (int w = 0; w < 100; w++) begin
        @(posedge clk_sys);
        // the last match shows up on the same edge as irq
        if (ssp_shift_tick === 1'b1)
          cnt++;
        if (irq === 1'b1)
          break;
      end
      check(cnt, n + 1, "matches per flag");
      bus_wr(IDX_CTL, 8'h00);
      repeat (20) @(posedge clk_sys);
      bus_rd(IDX_FLAGS, 8'h02);
      check({31'h0000_0000, irq}, 32'h0000_0001, "irq with flag and enable");
      bus_wr(IDX_EN, 8'h00);
      repeat (2) @(posedge clk_sys);
      check({31'h0000_0000, irq}, 32'h0000_0000, "irq masked");
    end
    repeat (4) @(posedge clk_sys);
    if (exp_q.size() != 0)
      check(exp_q.size(), 0, "reads left over");
    end_of_test();
  end
endmodule // period_match_timer8_test
`default_nettype wire
